// [logic/isp_pkg.sv]
`default_nettype none
package isp_pkg;
  // register offsets (not multiples of four: index, byte address = 4 * index)
  localparam logic [7:0] ISP_IDX_CONTROL = 8'h57;
  localparam logic [7:0] ISP_IDX_STATUS = 8'h58;
  localparam logic [7:0] ISP_IDX_OWN_ID = 8'h59;
  localparam logic [7:0] ISP_IDX_DATA = 8'h5A;
  localparam int ISP_ADDR_LSB = 2;
  // serial_control fields
  localparam int ISP_CTL_WRITE_COLLISION_FLAG = 7;
  localparam int ISP_CTL_OVF = 6;
  localparam int ISP_CTL_EN = 5;
  localparam int ISP_CTL_CKREL = 4;
  // serial_status fields
  localparam int ISP_STA_DA = 5;
  localparam int ISP_STA_STOP = 4;
  localparam int ISP_STA_START = 3;
  localparam int ISP_STA_RW = 2;
  localparam int ISP_STA_BF = 0;
  // reset values
  localparam logic [7:0] ISP_RST_OWN_ID = 8'h00;
  localparam logic [7:0] ISP_RST_DATA = 8'h00;
  localparam logic ISP_RST_CKREL = 1'b1;
  // byte framing
  localparam logic [3:0] ISP_BITS_PER_BYTE = 4'h8;
  // bus state machine, one-hot
  typedef enum logic [4:0] {
    ISP_IDLE = 5'h01,
    ISP_ADDR = 5'h02,
    ISP_ACK = 5'h04,
    ISP_RX = 5'h08,
    ISP_TX = 5'h10
  } isp_state_e;
endpackage
`default_nettype wire

// [logic/isp_i2c_slave_port.sv]
// Contract
// RULE_01: slave only; never drives its own clock
// RULE_02: master drives clock, id and commands
// RULE_03: compare id after start, then direction
// RULE_04: acknowledge on matching id
// RULE_05: detector watches for start and stop
// RULE_06: shift bits, copy whole byte to buffer
// RULE_07: one buffer for both directions
// RULE_08: write collision flag, software clear only
// RULE_09: receive overflow flag, software clear only
// RULE_10: enable bit switches the port on
// RULE_11: clock release bit, low holds scl
// RULE_12: data or address flag of last byte
// RULE_13: stop flag, cleared while disabled
// RULE_14: start flag, cleared while disabled
// RULE_15: direction flag one on read; the code sets it to one on a master write and then receives
// RULE_16: buffer full flag while byte waits
// RULE_17: own id register, resets to zero
// RULE_18: auto acknowledge and raise transfer flag
// RULE_19: overrun sets overflow, no transfer flag
// RULE_20: upper seven id bits match address
//
// The implementer's own choice: the APB interface to the registers.
`default_nettype none
module isp_i2c_slave_port
  import isp_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // two-wire pins, enable low while driving low
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // cpu event flag, one per received byte acknowledged while the buffer is free
  output logic transfer_irq_flag
);
  import isp_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] scl_sync_q; // stage 0 read only by stage 1
  logic [2:0] sda_sync_q;
  logic scl_q; // filtered levels
  logic sda_q;

  // three stages; a level counts once stages 1 and 2 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
    end
  end

  // accept a new level only when the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_q <= sda_sync_q[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // edge and condition detect
  // ----------------------------------------------------------------
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // previous filtered levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_q;
      sda_prev_q <= sda_q;
    end
  end

  assign scl_rise = scl_q && !scl_prev_q;
  assign scl_fall = !scl_q && scl_prev_q;
  // sda moving while scl high marks start or stop
  assign start_det = scl_q && scl_prev_q && sda_prev_q && !sda_q; // see RULE_05
  assign stop_det = scl_q && scl_prev_q && !sda_prev_q && sda_q; // see RULE_05

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic write_collision_flag_q; // write collision
  logic ovf_q; // receive overflow
  logic en_q; // module enable
  logic ckrel_q; // clock release
  logic da_q; // last byte was data
  logic stop_q;
  logic start_q;
  logic rw_q; // master write
  logic bf_q; // buffer full
  logic [7:0] own_id_q;
  logic [7:0] data_q;

  // apb decode
  logic [9:0] reg_idx;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic wr_data;
  logic rd_data;
  assign reg_idx = paddr[11:ISP_ADDR_LSB];
  assign hit = (reg_idx == {2'h0, ISP_IDX_CONTROL}) || (reg_idx == {2'h0, ISP_IDX_STATUS})
    || (reg_idx == {2'h0, ISP_IDX_OWN_ID}) || (reg_idx == {2'h0, ISP_IDX_DATA});
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_en = psel && penable && !pwrite && hit;
  assign wr_data = wr_en && (reg_idx == {2'h0, ISP_IDX_DATA});
  assign rd_data = rd_en && (reg_idx == {2'h0, ISP_IDX_DATA});

  // shifter state
  isp_state_e state_q;
  logic [7:0] shift_q; // bit shift register
  logic [3:0] bit_cnt_q;
  logic sda_low_q; // drive sda low
  logic ack_last_q; // ack slot was for the address byte
  logic byte_done; // eighth bit sampled in a receive state
  logic [7:0] byte_val;
  logic id_match;

  assign byte_val = {shift_q[6:0], sda_q};
  assign byte_done = scl_rise && (bit_cnt_q == ISP_BITS_PER_BYTE - 4'h1)
    && (state_q == ISP_ADDR || state_q == ISP_RX);
  assign id_match = (byte_val[7:1] == own_id_q[7:1]); // see RULE_03, RULE_20

  // apb answers in the access cycle, zero wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !((paddr[11:ISP_ADDR_LSB] == {2'h0, ISP_IDX_CONTROL})
        || (paddr[11:ISP_ADDR_LSB] == {2'h0, ISP_IDX_STATUS})
        || (paddr[11:ISP_ADDR_LSB] == {2'h0, ISP_IDX_OWN_ID})
        || (paddr[11:ISP_ADDR_LSB] == {2'h0, ISP_IDX_DATA}));
      prdata <= 32'h0;
      if (psel && !penable && !pwrite) begin
        case (paddr[11:ISP_ADDR_LSB])
          {2'h0, ISP_IDX_CONTROL}: prdata[7:4] <= {write_collision_flag_q, ovf_q, en_q, ckrel_q};
          {2'h0, ISP_IDX_STATUS}: prdata[7:0] <= {2'h0, da_q, stop_q, start_q, rw_q, 1'b0, bf_q};
          {2'h0, ISP_IDX_OWN_ID}: prdata[7:0] <= own_id_q;
          {2'h0, ISP_IDX_DATA}: prdata[7:0] <= data_q;
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // control bits: enable and clock release written directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      ckrel_q <= ISP_RST_CKREL; // see RULE_11
    end else if (wr_en && reg_idx == {2'h0, ISP_IDX_CONTROL}) begin
      en_q <= pwdata[ISP_CTL_EN]; // see RULE_10
      ckrel_q <= pwdata[ISP_CTL_CKREL]; // see RULE_11
    end
  end

  // sticky error flags; a hardware set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_collision_flag_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (wr_en && reg_idx == {2'h0, ISP_IDX_CONTROL}) begin
        write_collision_flag_q <= pwdata[ISP_CTL_WRITE_COLLISION_FLAG] && write_collision_flag_q;
        ovf_q <= pwdata[ISP_CTL_OVF] && ovf_q;
      end
      // buffer written while a byte is still going out
      if (wr_data && state_q == ISP_TX) begin
        write_collision_flag_q <= 1'b1; // see RULE_08
      end
      // byte lands while the previous one is unread
      if (byte_done && bf_q && !rd_data) begin
        ovf_q <= 1'b1; // see RULE_09, RULE_19
      end
    end
  end

  // own id register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_id_q <= ISP_RST_OWN_ID; // see RULE_17
    end else if (wr_en && reg_idx == {2'h0, ISP_IDX_OWN_ID}) begin
      own_id_q <= pwdata[7:0]; // see RULE_17
    end
  end

  // shared buffer and full flag; overrun keeps the old byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= ISP_RST_DATA;
      bf_q <= 1'b0;
    end else begin
      if (wr_data) begin
        data_q <= pwdata[7:0]; // see RULE_07
      end else if (rd_data) begin
        bf_q <= 1'b0; // see RULE_16
      end
      if (byte_done && (!bf_q || rd_data) && (state_q == ISP_RX || id_match)) begin
        data_q <= byte_val; // see RULE_06, RULE_07
        bf_q <= 1'b1; // see RULE_16
      end
    end
  end

  // status flags: start, stop, direction, data or address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
      rw_q <= 1'b0;
      da_q <= 1'b0;
    end else if (!en_q) begin
      start_q <= 1'b0; // see RULE_14
      stop_q <= 1'b0; // see RULE_13
    end else begin
      if (start_det) begin
        start_q <= 1'b1; // see RULE_14
        stop_q <= 1'b0;
      end
      if (stop_det) begin
        stop_q <= 1'b1; // see RULE_13
        start_q <= 1'b0;
      end
      if (byte_done && state_q == ISP_ADDR && id_match) begin
        rw_q <= byte_val[0]; // see RULE_15
        da_q <= 1'b0; // see RULE_12
      end else if (byte_done && state_q == ISP_RX) begin
        da_q <= 1'b1; // see RULE_12
      end
    end
  end

  // ----------------------------------------------------------------
  // serial state machine
  // ----------------------------------------------------------------
  // advances on scl edges and on start or stop, never makes its own clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ISP_IDLE;
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      sda_low_q <= 1'b0;
      ack_last_q <= 1'b0;
      transfer_irq_flag <= 1'b0;
    end else begin
      transfer_irq_flag <= 1'b0;
      if (!en_q || stop_det) begin
        state_q <= ISP_IDLE;
        sda_low_q <= 1'b0;
      end else if (start_det) begin
        state_q <= ISP_ADDR; // see RULE_01, RULE_02
        bit_cnt_q <= 4'h0;
        sda_low_q <= 1'b0;
      end else begin
        case (state_q)
          ISP_IDLE: begin
            sda_low_q <= 1'b0;
          end
          ISP_ADDR, ISP_RX: begin
            if (scl_rise) begin
              shift_q <= byte_val; // see RULE_06
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (byte_done) begin
              if (state_q == ISP_RX && bf_q && !rd_data) begin
                // overrun: no acknowledge, wait for the next start or stop
                state_q <= ISP_IDLE; // see RULE_19
              end else if (state_q == ISP_RX || id_match) begin
                // ack is a driven low; no ack on a data-byte overrun, an address byte still gets one
                ack_last_q <= (state_q == ISP_ADDR);
                state_q <= ISP_ACK; // see RULE_03, RULE_04
                transfer_irq_flag <= (!bf_q || rd_data); // see RULE_18, RULE_19
              end else begin
                state_q <= ISP_IDLE; // see RULE_03
              end
            end
          end
          ISP_ACK: begin
            if (scl_fall && !sda_low_q) begin
              sda_low_q <= 1'b1; // see RULE_04, RULE_18
            end else if (scl_fall && sda_low_q) begin
              sda_low_q <= 1'b0;
              bit_cnt_q <= 4'h0;
              // after a data byte keep receiving; after the address follow direction
              if (rw_q || !ack_last_q) begin
                state_q <= ISP_RX; // see RULE_15
              end else begin
                state_q <= ISP_TX;
                shift_q <= data_q; // see RULE_07
                sda_low_q <= !data_q[7];
              end
            end
          end
          ISP_TX: begin
            if (scl_fall) begin
              if (bit_cnt_q == ISP_BITS_PER_BYTE - 4'h1) begin
                state_q <= ISP_IDLE; // release for master ack
                sda_low_q <= 1'b0;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                sda_low_q <= !shift_q[6];
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
          end
          default: state_q <= ISP_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // open drain: enable low drives a zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_out <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_n <= !(en_q && !ckrel_q); // see RULE_11
      sda_oe_n <= !(en_q && sda_low_q); // see RULE_04
    end
  end
endmodule
`default_nettype wire

// [dv/isp_i2c_master_model.sv]
`default_nettype none
// ----------------------------------------
// behavioural two-wire bus master
// ----------------------------------------
module isp_i2c_master_model (
  // system clock and resolved lines
  input wire logic clk,
  input wire logic scl_line,
  input wire logic sda_line,
  // open-drain drives, 1 = released
  output logic scl_drv,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idles released
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // third of a bit time
  task half;
    repeat (16) @(posedge clk);
  endtask
  // sda falls while scl high; the master alone clocks the bus
  task start;
    sda_drv <= 1'b0;
    half;
    scl_drv <= 1'b0;
  endtask
  // one bit; sda only moves well inside the low phase
  task xb(input logic b, output logic r);
    half;
    sda_drv <= b;
    half;
    scl_drv <= 1'b1;
    half;
    r = sda_line;
    scl_drv <= 1'b0;
  endtask
  // msb first, then sample the acknowledge slot
  task wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xb(v[i], r);
    xb(1'b1, r);
    ack = !r;
  endtask
  // read a byte and answer not-acknowledge
  task rbyte(output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xb(1'b1, r);
      v[i] = r;
    end
    xb(1'b1, r);
  endtask
  // sda rises while scl high
  task stop;
    half;
    sda_drv <= 1'b0;
    half;
    scl_drv <= 1'b1;
    half;
    sda_drv <= 1'b1;
    half;
  endtask
endmodule
`default_nettype wire

// [dv/isp_i2c_slave_port_assertions.sv]
`default_nettype none
module isp_i2c_slave_port_assertions (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // pins and event
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic transfer_irq_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // bus and pin relations
  // ----------------------------------------
  a_open_drain: assert property (!scl_out && !sda_out)
    else $error("pin data not low");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("no ready in access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error reply malformed");
  a_irq_pulse: assert property (transfer_irq_flag |=> !transfer_irq_flag)
    else $error("transfer flag not a pulse");
  a_irq_scl_high: assert property (transfer_irq_flag |-> scl_in)
    else $error("byte done outside clock high");
  a_ack_after_irq: assert property (transfer_irq_flag |-> ##[1:48] !sda_oe_n)
    else $error("no acknowledge after byte");
  a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data moved with clock high");
endmodule
bind isp_i2c_slave_port isp_i2c_slave_port_assertions u_chk (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .prdata, .scl_in, .scl_out, .sda_out, .sda_oe_n, .transfer_irq_flag);
`default_nettype wire

// [dv/tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import isp_pkg::*;
  // ----------------------------------------
  // stimulus and wires
  // ----------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lerr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n, irq, m_scl, m_sda;
  logic [15:0] seed = 16'hD708;
  int mismatches = 0, cmp_count = 0, irq_n = 0;
  // pull-ups: a line is low if any party pulls it
  wire logic scl_w = m_scl & (scl_oe_n | scl_out);
  wire logic sda_w = m_sda & (sda_oe_n | sda_out);
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (irq === 1'b1) irq_n <= irq_n + 1;
  isp_i2c_slave_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .transfer_irq_flag(irq));
  isp_i2c_master_model m (.clk(pclk), .scl_line(scl_w), .sda_line(sda_w), .scl_drv(m_scl),
    .sda_drv(m_sda));
  // ----------------------------------------
  // expectations and bus tasks
  // ----------------------------------------
  function logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function logic [7:0] ctl(input logic wc, ov, en, ck);
    return {wc, ov, en, ck, 4'h0};
  endfunction
  function logic [7:0] adr(input logic [7:0] i, input logic rw);
    return {i[7:1], rw};
  endfunction
  task chk(input logic [7:0] g, e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task apb(input logic w, input logic [7:0] idx, wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd = prdata[7:0];
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] idx, d);
    logic [7:0] x;
    apb(1'b1, idx, d, x);
  endtask
  task rc(input logic [7:0] idx, e, mk);
    logic [7:0] x;
    apb(1'b0, idx, 8'h00, x);
    chk(x & mk, e);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard, several times the expected run
  initial begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    final_report;
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [7:0] id, e, t, b;
    logic ack;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rc(ISP_IDX_CONTROL, ctl(0, 0, 0, 1), 8'hFF);
    rc(ISP_IDX_STATUS, 8'h00, 8'hFF);
    rc(ISP_IDX_OWN_ID, 8'h00, 8'hFF);
    rc(ISP_IDX_DATA, 8'h00, 8'hFF);
    rc(8'h5B, 8'h00, 8'hFF);
    chk({7'h0, lerr}, 8'h01);
    seed = nxt(seed);
    id = seed[7:0];
    wr(ISP_IDX_OWN_ID, id);
    rc(ISP_IDX_OWN_ID, id, 8'hFF);
    wr(ISP_IDX_CONTROL, ctl(0, 0, 1, 1));
    $display("test registers done");
    m.start();
    rc(ISP_IDX_STATUS, 8'h08, 8'h18);
    m.wbyte(adr(id, 1'b1), ack);
    chk({7'h0, ack}, 8'h01);
    rc(ISP_IDX_STATUS, 8'h05, 8'h25);
    rc(ISP_IDX_DATA, adr(id, 1'b1), 8'hFF);
    for (int i = 0; i < 3; i++) begin
      seed = nxt(seed);
      e = seed[7:0];
      m.wbyte(e, ack);
      chk({7'h0, ack}, 8'h01);
      rc(ISP_IDX_STATUS, 8'h21, 8'h21);
      if (i < 2) rc(ISP_IDX_DATA, e, 8'hFF);
    end
    seed = nxt(seed);
    m.wbyte(seed[7:0], ack);
    chk({7'h0, ack}, 8'h00);
    rc(ISP_IDX_CONTROL, ctl(0, 1, 1, 1), 8'hFF);
    rc(ISP_IDX_DATA, e, 8'hFF);
    rc(ISP_IDX_STATUS, 8'h00, 8'h01);
    chk(irq_n[7:0], 8'h04);
    m.stop();
    rc(ISP_IDX_STATUS, 8'h10, 8'h10);
    wr(ISP_IDX_CONTROL, ctl(0, 0, 1, 1));
    rc(ISP_IDX_CONTROL, ctl(0, 0, 1, 1), 8'hFF);
    $display("test receive done");
    m.start();
    m.wbyte(adr(~id, 1'b1), ack);
    chk({7'h0, ack}, 8'h00);
    rc(ISP_IDX_STATUS, 8'h00, 8'h01);
    m.stop();
    $display("test mismatch done");
    seed = nxt(seed);
    t = seed[7:0];
    m.start();
    fork
      m.wbyte(adr(id, 1'b0), ack);
      begin
        @(posedge pclk iff irq === 1'b1);
        rc(ISP_IDX_DATA, adr(id, 1'b0), 8'hFF);
        wr(ISP_IDX_DATA, t);
      end
    join
    chk({7'h0, ack}, 8'h01);
    rc(ISP_IDX_STATUS, 8'h00, 8'h24);
    fork
      m.rbyte(b);
      begin
        repeat (60) @(posedge pclk);
        wr(ISP_IDX_DATA, ~t);
      end
    join
    chk(b, t);
    rc(ISP_IDX_CONTROL, ctl(1, 0, 1, 1), 8'hFF);
    m.stop();
    wr(ISP_IDX_CONTROL, ctl(0, 0, 1, 1));
    rc(ISP_IDX_CONTROL, ctl(0, 0, 1, 1), 8'hFF);
    $display("test transmit done");
    wr(ISP_IDX_CONTROL, ctl(0, 0, 0, 1));
    rc(ISP_IDX_STATUS, 8'h00, 8'h18);
    m.start();
    m.wbyte(adr(id, 1'b1), ack);
    chk({7'h0, ack}, 8'h00);
    m.stop();
    wr(ISP_IDX_CONTROL, ctl(0, 0, 1, 0));
    repeat (3) @(posedge pclk);
    chk({7'h0, scl_oe_n}, 8'h00);
    wr(ISP_IDX_CONTROL, ctl(0, 0, 1, 1));
    repeat (3) @(posedge pclk);
    chk({7'h0, scl_oe_n}, 8'h01);
    $display("test enable done");
    final_report;
  end
endmodule
`default_nettype wire
